// ### bus_signal_if.sv
`timescale 1ns/1ps
`include "bus_if_defs.svh"
module bus_signal_if (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic suspend,
	input wire logic [31:0] ad_in,
	output logic [31:0] ad_out,
	output logic ad_oe,
	input wire logic [3:0] cbe_n_in,
	output logic [3:0] cbe_n_out,
	output logic cbe_oe,
	input wire logic frame_n_in,
	output logic frame_n_out,
	output logic frame_oe,
	input wire logic irdy_n_in,
	output logic irdy_n_out,
	output logic irdy_oe,
	input wire logic trdy_n_in,
	output logic trdy_n_out,
	output logic trdy_oe,
	input wire logic devsel_n_in,
	output logic devsel_n_out,
	output logic devsel_oe,
	input wire logic idsel,
	input wire logic clkrun_n_in,
	output logic clkrun_n_out,
	output logic clkrun_oe,
	output logic clk_request,
	input wire logic sub_decode_en,
	input wire logic [31:0] io_base,
	input wire logic [31:0] io_mask,
	input wire logic [31:0] fwd_base,
	input wire logic [31:0] fwd_mask,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [31:0] req_addr,
	input wire logic [3:0] req_cmd,
	input wire logic [31:0] req_wdata,
	input wire logic [3:0] req_be_n,
	input wire logic req_last,
	output logic [31:0] rsp_rdata,
	output logic rsp_valid,
	output logic rsp_abort,
	output logic [31:0] tgt_addr,
	output logic [3:0] tgt_cmd,
	output logic tgt_start,
	output logic [35:0] tgt_wdata,
	output logic tgt_wvalid,
	input wire logic tgt_wready,
	input wire logic [31:0] tgt_rdata
);
	// Pin synchronisers
	logic [31:0] ad_m, ad_s;
	logic [3:0] cbe_m, cbe_s;
	logic [5:0] ctl_m, ctl_s;
	logic frame_s, irdy_s, trdy_s, devsel_s, idsel_s, clkrun_s;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ad_m <= '0;
			ad_s <= '0;
			cbe_m <= 4'hf;
			cbe_s <= 4'hf;
			ctl_m <= 6'h2f;
			ctl_s <= 6'h2f;
		end else begin
			ad_m <= ad_in;
			ad_s <= ad_m;
			cbe_m <= cbe_n_in;
			cbe_s <= cbe_m;
			ctl_m <= {clkrun_n_in, idsel, devsel_n_in, trdy_n_in, irdy_n_in,
				frame_n_in};
			ctl_s <= ctl_m;
		end
	end
	assign frame_s = ctl_s[0];
	assign irdy_s = ctl_s[1];
	assign trdy_s = ctl_s[2];
	assign devsel_s = ctl_s[3];
	assign idsel_s = ctl_s[4];
	assign clkrun_s = ctl_s[5];

	function automatic logic hit(input logic [31:0] a, input logic [31:0] b,
		input logic [31:0] m);
		hit = ((a ^ b) & m) == '0;
	endfunction
	function automatic logic is_write(input logic [3:0] c);
		is_write = c[0];
	endfunction

	// Write data toward the inside passes the FIFO
	logic [35:0] fin_data;
	logic fin_valid, fin_ready;
	word_fifo #(.WIDTH(36), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) wfifo (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.in_data(fin_data),
		.in_valid(fin_valid),
		.in_ready(fin_ready),
		.out_data(tgt_wdata),
		.out_valid(tgt_wvalid),
		.out_ready(tgt_wready)
	);

	bus_pkg::state_e st_reg, st_next;
	logic [31:0] ad_reg, ad_next, addr_reg, addr_next;
	logic [3:0] cbe_reg, cbe_next, cmd_reg, cmd_next;
	logic [2:0] sub_reg, sub_next;
	logic frame_reg, frame_next, irdy_reg, irdy_next;
	logic trdy_reg, trdy_next, devsel_reg, devsel_next;
	logic adoe_reg, adoe_next, mst_reg, mst_next, last_reg, last_next;
	logic frame_prev_reg, tgt_wr, claim_pos, claim_cfg, fstart, done;
	logic [31:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next, abort_reg, abort_next, start_reg;
	logic start_next;

	always_comb begin
		fstart = frame_prev_reg && !frame_s && irdy_s;
		claim_cfg = idsel_s && (cbe_s == `CMD_CFG_READ ||
			cbe_s == `CMD_CFG_WRITE);
		claim_pos = hit(ad_s, io_base, io_mask) ||
			hit(ad_s, fwd_base, fwd_mask);
		tgt_wr = is_write(cmd_reg);
		done = !irdy_s && !trdy_s;
		st_next = st_reg;
		ad_next = ad_reg;
		addr_next = addr_reg;
		cbe_next = cbe_reg;
		cmd_next = cmd_reg;
		sub_next = sub_reg;
		frame_next = frame_reg;
		irdy_next = irdy_reg;
		trdy_next = trdy_reg;
		devsel_next = devsel_reg;
		adoe_next = adoe_reg;
		mst_next = mst_reg;
		last_next = last_reg;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		abort_next = 1'b0;
		start_next = 1'b0;
		fin_valid = 1'b0;
		fin_data = {cbe_s, ad_s};
		req_ready = 1'b0;
		case (st_reg)
			bus_pkg::ST_IDLE: begin
				if (fstart) begin
					addr_next = ad_s;
					cmd_next = cbe_s;
					sub_next = '0;
					if (claim_cfg || claim_pos) begin
						devsel_next = 1'b0;
						start_next = 1'b1;
						st_next = bus_pkg::ST_TGT;
					end else if (sub_decode_en) begin
						st_next = bus_pkg::ST_WAIT;
					end
				end else if (req_valid && frame_s && irdy_s && !suspend) begin
					req_ready = 1'b1;
					mst_next = 1'b1;
					frame_next = 1'b0;
					ad_next = {req_addr[31:2], `AD_LOW_ZERO};
					cbe_next = req_cmd;
					cmd_next = req_cmd;
					adoe_next = 1'b1;
					st_next = bus_pkg::ST_ADDR;
				end
			end
			bus_pkg::ST_WAIT: begin
				sub_next = sub_reg + 3'h1;
				if (!devsel_s) begin
					st_next = bus_pkg::ST_IDLE;
				end else if (sub_reg == `SUB_DELAY) begin
					devsel_next = 1'b0;
					start_next = 1'b1;
					st_next = bus_pkg::ST_TGT;
				end
			end
			bus_pkg::ST_TGT: begin
				trdy_next = tgt_wr ? !fin_ready : 1'b0;
				adoe_next = !tgt_wr;
				ad_next = tgt_rdata;
				if (!trdy_reg && !irdy_s && tgt_wr) begin
					fin_valid = 1'b1;
				end
				if (!trdy_reg && !irdy_s && frame_s) begin
					trdy_next = 1'b1;
					devsel_next = 1'b1;
					adoe_next = 1'b0;
					st_next = bus_pkg::ST_TURN;
				end
			end
			bus_pkg::ST_ADDR: begin
				irdy_next = 1'b0;
				ad_next = req_wdata;
				cbe_next = req_be_n;
				adoe_next = is_write(cmd_reg);
				last_next = req_last;
				frame_next = req_last;
				sub_next = '0;
				st_next = bus_pkg::ST_DATA;
			end
			bus_pkg::ST_DATA: begin
				sub_next = sub_reg + 3'h1;
				if (devsel_s && sub_reg == `SUB_DELAY + 3'h2) begin
					abort_next = 1'b1;
					st_next = bus_pkg::ST_TURN;
				end else if (done) begin
					rdata_next = ad_s;
					rvalid_next = !is_write(cmd_reg);
					if (last_reg) begin
						st_next = bus_pkg::ST_TURN;
					end else begin
						req_ready = 1'b1;
						ad_next = req_wdata;
						cbe_next = req_be_n;
						last_next = req_last;
						frame_next = req_last;
					end
				end
				if (st_next == bus_pkg::ST_TURN) begin
					frame_next = 1'b1;
					irdy_next = 1'b1;
					adoe_next = 1'b0;
				end
			end
			bus_pkg::ST_TURN: begin
				mst_next = 1'b0;
				st_next = bus_pkg::ST_IDLE;
			end
			default: st_next = bus_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= bus_pkg::ST_IDLE;
			ad_reg <= '0;
			addr_reg <= '0;
			cbe_reg <= 4'hf;
			cmd_reg <= '0;
			sub_reg <= '0;
			frame_reg <= 1'b1;
			irdy_reg <= 1'b1;
			trdy_reg <= 1'b1;
			devsel_reg <= 1'b1;
			adoe_reg <= 1'b0;
			mst_reg <= 1'b0;
			last_reg <= 1'b0;
			rdata_reg <= '0;
			rvalid_reg <= 1'b0;
			abort_reg <= 1'b0;
			start_reg <= 1'b0;
			frame_prev_reg <= 1'b1;
		end else begin
			st_reg <= st_next;
			ad_reg <= ad_next;
			addr_reg <= addr_next;
			cbe_reg <= cbe_next;
			cmd_reg <= cmd_next;
			sub_reg <= sub_next;
			frame_reg <= frame_next;
			irdy_reg <= irdy_next;
			trdy_reg <= trdy_next;
			devsel_reg <= devsel_next;
			adoe_reg <= adoe_next;
			mst_reg <= mst_next;
			last_reg <= last_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			abort_reg <= abort_next;
			start_reg <= start_next;
			frame_prev_reg <= frame_s;
		end
	end

	// Pin drive; all float in suspend, all but clock-run in reset
	always_comb begin
		ad_out = ad_reg;
		cbe_n_out = cbe_reg;
		frame_n_out = frame_reg;
		irdy_n_out = irdy_reg;
		trdy_n_out = trdy_reg;
		devsel_n_out = devsel_reg;
		ad_oe = adoe_reg && !suspend;
		cbe_oe = mst_reg && !suspend;
		frame_oe = mst_reg && !suspend;
		irdy_oe = mst_reg && !suspend;
		trdy_oe = (st_reg == bus_pkg::ST_TGT) && !suspend;
		devsel_oe = (st_reg == bus_pkg::ST_TGT) && !suspend;
		clkrun_n_out = 1'b0;
		clkrun_oe = !suspend;
		clk_request = suspend && !clkrun_s;
		rsp_rdata = rdata_reg;
		rsp_valid = rvalid_reg;
		rsp_abort = abort_reg;
		tgt_addr = addr_reg;
		tgt_cmd = cmd_reg;
		tgt_start = start_reg;
	end
endmodule

// ### bus_if_defs.svh
// Operation
// - First clock carries a 32-bit byte address, later clocks carry data
// - One address phase, then one or more data phases per transaction
// - Little-endian lanes: bits 7..0 low byte, bits 31..24 high byte
// - As initiator drive address with low two bits zero, then write data
// - As target sample address, then supply read or accept write data
// - Command/byte-enable lines carry the command in the address phase
// - In data phases active-low enable n marks byte lane n meaningful
// - Negated enables mark lanes the receiver ignores
// - Device drives clock-run low; peripherals may assert it to keep clock
// - Claim configuration cycles with chip-select and internal decodes
// - Claim positive decodes, or subtractively only when enabled
// - As initiator, device-select is an input showing a target answered
// - Initiator asserts frame at start and holds it until the final data phase
// - Frame asserted means transfers continue; negated means final phase
// - Frame driven only as initiator, input otherwise
// - Chip-select sampled in address phase; claim after the two-stage pin synchroniser delay
// - A data phase completes when both ready signals are sampled asserted
`ifndef BUS_IF_DEFS_SVH
`define BUS_IF_DEFS_SVH
`define CMD_IO_READ 4'h2
`define CMD_IO_WRITE 4'h3
`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7
`define CMD_CFG_READ 4'ha
`define CMD_CFG_WRITE 4'hb
`define SUB_DELAY 3'h3
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define AD_LOW_ZERO 2'h0
`define BE_ALL 4'h0
`endif

// ### bus_pkg.sv
package bus_pkg;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_TGT = 6'h02,
		ST_ADDR = 6'h04,
		ST_DATA = 6'h08,
		ST_TURN = 6'h10,
		ST_WAIT = 6'h20
	} state_e;
endpackage

// ### word_fifo.sv
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0] wp_reg, wp_next, rp_reg, rp_next, cnt;
	logic push, pop;
	always_comb begin
		cnt = wp_reg - rp_reg;
		in_ready = cnt != (AW+1)'(DEPTH);
		out_valid = cnt != '0;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wp_next = push ? wp_reg + 1'b1 : wp_reg;
		rp_next = pop ? rp_reg + 1'b1 : rp_reg;
		out_data = mem_reg[rp_reg[AW-1:0]];
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_reg <= '0;
			rp_reg <= '0;
		end else begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
		end
	end
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_reg[wp_reg[AW-1:0]] <= in_data;
		end
	end
endmodule

// ### bus_signal_if_checker.sv
`timescale 1ns/1ps
module bus_chk (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic suspend,
	input wire logic [31:0] ad_out,
	input wire logic ad_oe,
	input wire logic [3:0] cbe_n_in,
	input wire logic cbe_oe,
	input wire logic frame_n_in,
	input wire logic frame_n_out,
	input wire logic frame_oe,
	input wire logic irdy_n_in,
	input wire logic irdy_n_out,
	input wire logic irdy_oe,
	input wire logic devsel_n_out,
	input wire logic devsel_oe,
	input wire logic idsel,
	input wire logic clkrun_n_out,
	input wire logic clkrun_oe,
	input wire logic tgt_start
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	chk_reset_float: assert property ($rose(rst_b) |->
		!(ad_oe | cbe_oe | frame_oe | devsel_oe)) else $error("bus driven");
	chk_susp_float: assert property (suspend[*3] |->
		!(ad_oe | cbe_oe | frame_oe | devsel_oe | irdy_oe))
		else $error("bus driven in suspend");
	chk_clkrun_low: assert property ((!suspend)[*2] |->
		clkrun_oe && !clkrun_n_out) else $error("clock run not low");
	chk_clkrun_free: assert property (suspend[*2] |-> !clkrun_oe)
		else $error("clock run held in suspend");
	chk_addr_zero: assert property (frame_oe && $fell(frame_n_out) |->
		ad_oe && cbe_oe && ad_out[1:0] == 2'h0) else $error("bad address");
	chk_irdy_next: assert property (frame_oe && $fell(frame_n_out) |=>
		irdy_oe && !irdy_n_out) else $error("no data phase");
	chk_init_only: assert property (frame_oe |-> !devsel_oe)
		else $error("claimed own cycle");
	chk_cfg_claim: assert property ($fell(frame_n_in) && irdy_n_in && idsel
		&& cbe_n_in[3:1] == 3'h5 && !frame_oe |->
		##[1:5] devsel_oe && !devsel_n_out) else $error("no config claim");
	chk_start_pulse: assert property (tgt_start |=> !tgt_start)
		else $error("start too long");
endmodule
bind bus_signal_if bus_chk i_chk (.*);

// ### far_target.sv
`timescale 1ns/1ps
module far_target (
	input wire logic core_clk,
	input wire logic slow,
	input wire logic frame_w,
	input wire logic irdy_w,
	input wire logic [3:0] cbe_w,
	input wire logic [31:0] rdata,
	output logic devsel_n,
	output logic trdy_n,
	output logic [31:0] p_ad,
	output logic p_oe
);
	logic prev_frame = 1'b1;
	logic busy = 1'b0;
	logic rd = 1'b0;
	int wait_cnt = 0;
	initial begin
		devsel_n = 1'b1;
		trdy_n = 1'b1;
		p_ad = 32'h0;
		p_oe = 1'b0;
	end
	// Claims after a prompt or slow wait; released data toggles
	always @(posedge core_clk) begin
		prev_frame <= frame_w;
		p_ad <= ~p_ad;
		if (prev_frame && !frame_w && irdy_w) begin
			busy <= 1'b1;
			rd <= !cbe_w[0];
			wait_cnt <= slow ? 2 : 0;
		end else if (busy && wait_cnt > 0) begin
			wait_cnt <= wait_cnt - 1;
		end else if (busy) begin
			devsel_n <= 1'b0;
			trdy_n <= 1'b0;
			p_oe <= rd;
			if (rd)
				p_ad <= rdata;
			if (!irdy_w && !trdy_n && frame_w) begin
				busy <= 1'b0;
				devsel_n <= 1'b1;
				trdy_n <= 1'b1;
				p_oe <= 1'b0;
			end
		end
	end
endmodule

// ### test_pci_bus_signal_interface.sv
`timescale 1ns/1ps
`include "bus_if_defs.svh"
module test_pci_bus_signal_interface;
	logic core_clk, rst_b, suspend, idsel, sub_decode_en, slow;
	logic [31:0] ad_in, ad_out, io_base, io_mask, fwd_base, fwd_mask;
	logic [31:0] req_addr, req_wdata, rsp_rdata, tgt_addr, tgt_rdata;
	logic [3:0] cbe_n_in, cbe_n_out, req_cmd, req_be_n, tgt_cmd, tb_cbe;
	logic ad_oe, cbe_oe, frame_n_in, frame_n_out, frame_oe, irdy_n_in;
	logic irdy_n_out, irdy_oe, trdy_n_in, trdy_n_out, trdy_oe, devsel_n_in;
	logic devsel_n_out, devsel_oe, clkrun_n_in, clkrun_n_out, clkrun_oe;
	logic clk_request, req_valid, req_ready, req_last, rsp_valid, rsp_abort;
	logic tgt_start, tgt_wvalid, tgt_wready, tb_frame, tb_irdy, tb_clk;
	logic p_devsel, p_trdy, p_oe;
	logic [35:0] tgt_wdata;
	logic [31:0] tb_ad, p_ad, p_data, seed, last_rdata;
	logic [31:0] rq[$];
	logic [35:0] wq[$];
	int fail_count, compares, cycles, starts;
	bus_signal_if i_dut (.*);
	far_target i_far (.core_clk(core_clk), .slow(slow),
		.frame_w(frame_oe ? frame_n_out : 1'b1), .irdy_w(irdy_n_in),
		.cbe_w(cbe_n_in), .rdata(p_data), .devsel_n(p_devsel),
		.trdy_n(p_trdy), .p_ad(p_ad), .p_oe(p_oe));
	assign frame_n_in = (frame_oe ? frame_n_out : 1'b1) & tb_frame;
	assign irdy_n_in = (irdy_oe ? irdy_n_out : 1'b1) & tb_irdy;
	assign trdy_n_in = (trdy_oe ? trdy_n_out : 1'b1) & p_trdy;
	assign devsel_n_in = (devsel_oe ? devsel_n_out : 1'b1) & p_devsel;
	assign cbe_n_in = cbe_oe ? cbe_n_out : tb_cbe;
	assign ad_in = ad_oe ? ad_out : p_oe ? p_ad : tb_ad;
	assign clkrun_n_in = (clkrun_oe ? clkrun_n_out : 1'b1) & tb_clk;
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic issue(input logic [3:0] cmd);
		int n;
		@(posedge core_clk);
		seed = lfsr(seed);
		p_data <= ~seed;
		req_addr <= seed;
		req_cmd <= cmd;
		req_wdata <= {seed[15:0], seed[31:16]};
		req_be_n <= seed[3:0];
		req_last <= 1'b1;
		req_valid <= 1'b1;
		for (n = 0; n < 40 && req_ready !== 1'b1; n++)
			@(negedge core_clk);
		@(posedge core_clk);
		req_valid <= 1'b0;
		for (n = 0; n < 40 && !(frame_oe && !frame_n_out); n++)
			@(negedge core_clk);
		check(ad_out, {seed[31:2], `AD_LOW_ZERO});
		check(cbe_n_out, cmd);
		@(negedge core_clk);
		check(irdy_n_out, 1'b0);
		if (cmd[0]) begin
			check(ad_out, {seed[15:0], seed[31:16]});
			check(cbe_n_out, seed[3:0]);
		end else
			rq.push_back(p_data);
		for (n = 0; n < 40 && irdy_oe; n++)
			@(negedge core_clk);
		check(irdy_oe, 1'b0);
		$display("initiator cycle %h done", cmd);
	endtask
	task automatic cfg_cycle(input logic [3:0] cmd, input logic sel);
		int n;
		int s;
		seed = lfsr(seed);
		s = starts;
		@(posedge core_clk);
		tb_ad <= {seed[31:2], 2'h0};
		tb_cbe <= cmd;
		idsel <= sel;
		tb_frame <= 1'b0;
		@(posedge core_clk);
		idsel <= 1'b0;
		tb_frame <= 1'b1;
		tb_irdy <= 1'b0;
		tb_cbe <= `BE_ALL;
		tb_ad <= ~seed;
		for (n = 0; n < 12 && devsel_n_in !== 1'b0; n++)
			@(negedge core_clk);
		check(n, sel ? 36'h3 : 36'h7);
		check(tgt_cmd, cmd);
		check(tgt_addr, {seed[31:2], 2'h0});
		if (cmd[0])
			wq.push_back({`BE_ALL, ~seed});
		for (n = 0; n < 40 && (trdy_oe || devsel_oe); n++)
			@(negedge core_clk);
		@(posedge core_clk);
		tb_irdy <= 1'b1;
		check(starts - s, 36'h1);
		$display("config cycle %h done", cmd);
	endtask
	always @(posedge core_clk) begin
		cycles++;
		tgt_rdata <= lfsr(tgt_rdata);
		last_rdata <= tgt_rdata;
		tgt_wready <= tgt_rdata[3];
		if (tgt_start)
			starts++;
		if (rsp_valid)
			check(rsp_rdata, rq.size() ? rq.pop_front() : 32'h0);
		check(rsp_abort, 1'b0);
		if (ad_oe && trdy_oe && !trdy_n_out)
			check(ad_out, last_rdata);
		if (tgt_wvalid && tgt_wready)
			check(tgt_wdata, wq.size() ? wq.pop_front() : 36'h0);
		if (cycles == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		{rst_b, suspend, idsel, slow, req_valid, req_last} = 6'h0;
		{tb_frame, tb_irdy, sub_decode_en, tb_clk} = 4'hf;
		{io_base, io_mask, fwd_base, fwd_mask} = {4{32'h3}};
		{req_addr, req_wdata, req_cmd, req_be_n, tb_cbe} = '0;
		{tb_ad, p_data, tgt_wready, last_rdata} = '0;
		tgt_rdata = 32'h1;
		seed = 32'h63;
		fail_count = 0;
		compares = 0;
		cycles = 0;
		starts = 0;
		repeat (5) @(posedge core_clk);
		check({ad_oe, cbe_oe, frame_oe, devsel_oe}, 4'h0);
		check({clkrun_oe, clkrun_n_out}, 2'h2);
		rst_b <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			slow <= i[2];
			issue(i[0] ? `CMD_MEM_WRITE : `CMD_MEM_READ);
			issue(i[1] ? `CMD_IO_WRITE : `CMD_IO_READ);
		end
		cfg_cycle(`CMD_CFG_WRITE, 1'b1);
		cfg_cycle(`CMD_CFG_READ, 1'b1);
		cfg_cycle(`CMD_MEM_WRITE, 1'b0);
		cfg_cycle(`CMD_IO_READ, 1'b0);
		for (int i = 0; i < 40 && wq.size() != 0; i++)
			@(posedge core_clk);
		check(wq.size(), 36'h0);
		suspend <= 1'b1;
		repeat (4) @(posedge core_clk);
		check({ad_oe, cbe_oe, frame_oe, devsel_oe, clkrun_oe}, 5'h0);
		check(clk_request, 1'b0);
		tb_clk <= 1'b0;
		repeat (4) @(posedge core_clk);
		check(clk_request, 1'b1);
		tb_clk <= 1'b1;
		suspend <= 1'b0;
		$display("suspend test done");
		end_of_test();
	end
endmodule
